// ---- hwm_bank_assertions.sv ----
// Concurrent checks on the ports of the monitor register bank.
// Assumes the bank is clocked by clk and reset by rst_n, active low.
module hwm_bank_assertions (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               port_sel,
    input wire logic               port_wr,
    input wire logic               port_rd,
    input wire hwm_pkg::hwm_byte_t port_wdata,
    input wire hwm_pkg::hwm_byte_t port_rdata,
    input wire logic               sample_valid,
    input wire logic               mgmt_irq_out_n,
    input wire logic               monitor_active,
    input wire logic [1:0]         fan_one_div,
    input wire logic [1:0]         fan_two_div
);
    hwm_pkg::hwm_index_t ptr;
    logic                busy;
    logic                dwr;
    logic                drd;
    assign dwr = port_wr && port_sel;
    assign drd = port_rd && port_sel;
    // Shadow of the index pointer and busy flag, used to decode accesses.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr  <= 7'h00;
            busy <= 1'b0;
        end else if (port_wr && !port_sel) begin
            ptr  <= port_wdata[6:0];
            busy <= 1'b1;
        end else if (dwr || drd) begin
            busy <= 1'b0;
            if (dwr && ptr == 7'h40 && port_wdata[7]) begin
                ptr <= 7'h00;
            end else if (ptr < 7'h1F || ptr == 7'h41 || ptr == 7'h43 ||
                         (ptr >= 7'h60 && ptr < 7'h7F)) begin
                ptr <= ptr + 7'h01;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RDATA_HOLD: assert property (
        !port_rd |=> $stable(port_rdata))
        else $error("read data moved without a read");
    AST_INDEX_READ: assert property (
        port_rd && !port_sel |=> port_rdata == {$past(busy), $past(ptr)})
        else $error("index read gave wrong busy or pointer");
    AST_CFG_FIELDS: assert property (
        drd && ptr == 7'h40 |=> port_rdata[7:4] == 4'h0 && !port_rdata[2])
        else $error("configuration reserved or reload bit read one");
    AST_MASK2_TOP: assert property (
        drd && ptr == 7'h44 |=> port_rdata[7:6] == 2'h0)
        else $error("second mask top bits read one");
    AST_RSVD_READ: assert property (
        drd && ptr inside {7'h21, 7'h61, 7'h45, 7'h48} |=> port_rdata == 8'h00)
        else $error("reserved place read nonzero");
    AST_MON_CFG: assert property (
        dwr && ptr == 7'h40 |=> monitor_active == ($past(port_wdata[7]) ||
        ($past(port_wdata[0]) && !$past(port_wdata[3]))))
        else $error("monitor state does not follow configuration");
    AST_DIV_WRITE: assert property (
        dwr && ptr == 7'h47 |=> {fan_two_div, fan_one_div} ==
        $past(port_wdata[7:4]))
        else $error("divisor outputs do not follow write");
    AST_CTRL_HOLD: assert property (
        !dwr |=> $stable({monitor_active, fan_two_div, fan_one_div}))
        else $error("control outputs moved without a data write");
    AST_IRQ_STICKY: assert property (
        !mgmt_irq_out_n && !port_rd && !port_wr && !$past(port_rd) &&
        !$past(port_wr) |=> !mgmt_irq_out_n)
        else $error("interrupt dropped without a host access");
    COV_SAMPLE: cover property (sample_valid && monitor_active);
    COV_IRQ: cover property ($fell(mgmt_irq_out_n));
    COV_IDX_READ: cover property (port_rd && !port_sel && busy);
endmodule

bind hwm_register_bank hwm_bank_assertions i_hwm_bank_assertions (
    .clk(clk), .rst_n(rst_n), .port_sel(port_sel), .port_wr(port_wr),
    .port_rd(port_rd), .port_wdata(port_wdata), .port_rdata(port_rdata),
    .sample_valid(sample_valid), .mgmt_irq_out_n(mgmt_irq_out_n),
    .monitor_active(monitor_active), .fan_one_div(fan_one_div),
    .fan_two_div(fan_two_div));

// ---- hwm_cfg.svh ----
// Constants of the hardware monitor register bank: indexes, field
// positions, reset values and value RAM layout.
// Assumes it is included by bare name from the register bank module.
`ifndef HWM_CFG_SVH
`define HWM_CFG_SVH

`define HWM_IDX_CFG      7'h40
`define HWM_IDX_STAT1    7'h41
`define HWM_IDX_STAT2    7'h42
`define HWM_IDX_MASK1    7'h43
`define HWM_IDX_MASK2    7'h44
`define HWM_IDX_CLR      7'h46
`define HWM_IDX_FDIV     7'h47
`define HWM_POST_TOP     7'h1F
`define HWM_VRAM_TOP     7'h7F

`define HWM_CFG_RST      8'h01
`define HWM_FDIV_RST     8'h5F
`define HWM_MASK_RST     8'h00
`define HWM_CFG_SOFT     7
`define HWM_CFG_SUSPEND  3
`define HWM_CFG_IRQ_EN   1
`define HWM_CFG_START    0
`define HWM_CLR_CASE     7

`define HWM_STAT1_USED   8'hFD
`define HWM_STAT2_USED   8'h17
`define HWM_MASK2_USED   8'h3F

`define HWM_ST_CORE      4'd0
`define HWM_ST_V3V3      4'd2
`define HWM_ST_V5        4'd3
`define HWM_ST_TEMP1     4'd4
`define HWM_ST_TEMP2     4'd5
`define HWM_ST_FAN_ONE      4'd6
`define HWM_ST_FAN_TWO      4'd7
`define HWM_ST_P12       4'd8
`define HWM_ST_N12       4'd9
`define HWM_ST_N5        4'd10
`define HWM_ST_CASE      4'd12

`define HWM_OFS_CORE     5'h00
`define HWM_OFS_V3V3     5'h02
`define HWM_OFS_V5       5'h03
`define HWM_OFS_P12      5'h04
`define HWM_OFS_N12      5'h05
`define HWM_OFS_N5       5'h06
`define HWM_OFS_TEMP1    5'h07
`define HWM_OFS_FAN_ONE     5'h08
`define HWM_OFS_FAN_TWO     5'h09
`define HWM_LIM_CORE     5'h0B
`define HWM_LIM_V3V3     5'h0F
`define HWM_LIM_V5       5'h11
`define HWM_LIM_P12      5'h13
`define HWM_LIM_N12      5'h15
`define HWM_LIM_N5       5'h17
`define HWM_LIM_TEMP1    5'h19
`define HWM_LIM_FAN_ONE     5'h1B
`define HWM_LIM_FAN_TWO     5'h1C

`endif

// ---- hwm_host_model.sv ----
// Host model that reaches the bank through its index and data ports.
// Assumes requests are raised after a falling edge of clk.
module hwm_host_model (
    input  wire logic               clk,
    input  wire hwm_pkg::hwm_byte_t port_rdata,
    output logic                    port_sel,
    output logic                    port_wr,
    output logic                    port_rd,
    output hwm_pkg::hwm_byte_t      port_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ports are idle at time zero.
    initial begin
        port_sel   = 1'b0;
        port_wr    = 1'b0;
        port_rd    = 1'b0;
        port_wdata = 8'h00;
    end
    // One write strobe held across one rising edge; data is then scrambled.
    task automatic wr(input logic s, input hwm_pkg::hwm_byte_t x);
        @(negedge clk);
        port_sel   = s;
        port_wdata = x;
        port_wr    = 1'b1;
        @(negedge clk);
        port_wr    = 1'b0;
        port_wdata = ~x;
    endtask
    // One read strobe; the answer is taken once the taking edge has passed.
    task automatic rd(input logic s, output hwm_pkg::hwm_byte_t x);
        @(negedge clk);
        port_sel = s;
        port_rd  = 1'b1;
        @(negedge clk);
        port_rd  = 1'b0;
        x        = port_rdata;
    endtask
endmodule

// ---- hwm_pkg.sv ----
// Types shared by the hardware monitor register bank.
// Assumes hwm_cfg.svh is on the include path.
package hwm_pkg;
    typedef logic [7:0] hwm_byte_t;
    typedef logic [6:0] hwm_index_t;
    // Kind of limit check applied to a fresh reading.
    typedef enum logic [1:0] {
        HWM_CHK_NONE,
        HWM_CHK_VOLT,
        HWM_CHK_TEMP,
        HWM_CHK_FAN
    } hwm_chk_e;
endpackage

// ---- hwm_register_bank.sv ----
// Hardware monitor register bank behind an index port and a data port,
// with POST RAM, value RAM, limit checks and the management interrupt.
// Assumes host strobes and converter samples come from logic on clk and
// only the case-open pin is asynchronous.
`include "hwm_cfg.svh"

module hwm_register_bank (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             port_sel,
    input  wire logic             port_wr,
    input  wire logic             port_rd,
    input  wire hwm_pkg::hwm_byte_t port_wdata,
    output hwm_pkg::hwm_byte_t    port_rdata,
    input  wire logic             sample_valid,
    input  wire logic [4:0]       sample_offset,
    input  wire hwm_pkg::hwm_byte_t sample_data,
    input  wire logic             thermal_two_event,
    input  wire logic             case_open_pin,
    output logic                  mgmt_irq_out_n,
    output logic                  monitor_active,
    output logic [1:0]            fan_one_div,
    output logic [1:0]            fan_two_div
);

    logic                rst_q1;
    logic                rst_q2;
    logic                case_s1;
    logic                case_s2;
    logic                case_s3;
    logic                case_level;
    logic                case_rise;
    logic                case_latch;
    hwm_pkg::hwm_index_t index_pointer;
    logic                index_busy;
    logic                cfg_suspend;
    logic                cfg_irq_en;
    logic                cfg_start;
    hwm_pkg::hwm_byte_t  mask_one;
    logic [5:0]          mask_two;
    logic [3:0]          fan_prescale;
    logic [15:0]         status;
    logic                irq_pend;
    hwm_pkg::hwm_byte_t  post_ram [32];
    hwm_pkg::hwm_byte_t  value_ram [32];
    logic                data_wr;
    logic                data_rd;
    logic                data_acc;
    logic                idx_wr;
    logic                in_post;
    logic                in_vram;
    logic [4:0]          vram_ofs;
    logic                soft_rst;
    logic                auto_inc;
    logic                sample_go;
    hwm_pkg::hwm_chk_e   chk_kind;
    logic [4:0]          chk_lim;
    logic [3:0]          chk_bit;
    hwm_pkg::hwm_byte_t  lim_hi;
    hwm_pkg::hwm_byte_t  lim_lo;
    logic                viol;
    logic                temp_hot;
    logic                next_temp_hot;
    logic [15:0]         stat_set;
    logic [15:0]         stat_clr;
    logic [15:0]         stat_used;
    logic [15:0]         unmasked;
    hwm_pkg::hwm_byte_t  rd_value;

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end

    // Case-open pin passes three flip-flops; a change counts on agreement.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            case_s1    <= 1'b0;
            case_s2    <= 1'b0;
            case_s3    <= 1'b0;
            case_level <= 1'b0;
        end else begin
            case_s1 <= case_open_pin;
            case_s2 <= case_s1;
            case_s3 <= case_s2;
            if (case_s2 == case_s3) begin
                case_level <= case_s3;
            end
        end
    end

    assign case_rise = (case_s2 == case_s3) && case_s3 && !case_level;

    // Host access decode for the two ports.
    assign data_wr  = port_sel && port_wr;
    assign data_rd  = port_sel && port_rd;
    assign data_acc = data_wr || data_rd;
    assign idx_wr   = !port_sel && port_wr;
    assign in_post  = index_pointer[6:5] == 2'b00;
    assign in_vram  = index_pointer[5];
    assign vram_ofs = index_pointer[4:0];
    assign soft_rst = data_wr && index_pointer == `HWM_IDX_CFG
                      && port_wdata[`HWM_CFG_SOFT];
    assign monitor_active = cfg_start && !cfg_suspend;
    assign sample_go = sample_valid && monitor_active;

    // Pointer steps forward in the windows that advance, never wrapping.
    always_comb begin
        auto_inc = 1'b0;
        if (in_post && index_pointer != `HWM_POST_TOP) begin
            auto_inc = 1'b1;
        end
        if (index_pointer[6:5] == 2'b11
            && index_pointer != `HWM_VRAM_TOP) begin
            auto_inc = 1'b1;
        end
        if (index_pointer == `HWM_IDX_STAT1
            || index_pointer == `HWM_IDX_MASK1) begin
            auto_inc = 1'b1;
        end
    end

    // Index port: pointer and busy flag.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            index_pointer <= 7'h00;
            index_busy    <= 1'b0;
        end else if (soft_rst) begin
            index_pointer <= 7'h00;
            index_busy    <= 1'b0;
        end else if (idx_wr) begin
            index_pointer <= port_wdata[6:0];
            index_busy    <= 1'b1;
        end else if (data_acc) begin
            index_busy <= 1'b0;
            if (auto_inc) begin
                index_pointer <= index_pointer + 7'h01;
            end
        end
    end

    // Control registers written through the data port.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            cfg_suspend  <= 1'(`HWM_CFG_RST >> `HWM_CFG_SUSPEND);
            cfg_irq_en   <= 1'(`HWM_CFG_RST >> `HWM_CFG_IRQ_EN);
            cfg_start    <= 1'(`HWM_CFG_RST >> `HWM_CFG_START);
            mask_one     <= `HWM_MASK_RST;
            mask_two     <= 6'h00;
            fan_prescale <= 4'(`HWM_FDIV_RST >> 4);
        end else if (soft_rst) begin
            cfg_suspend  <= 1'(`HWM_CFG_RST >> `HWM_CFG_SUSPEND);
            cfg_irq_en   <= 1'(`HWM_CFG_RST >> `HWM_CFG_IRQ_EN);
            cfg_start    <= 1'(`HWM_CFG_RST >> `HWM_CFG_START);
            mask_one     <= `HWM_MASK_RST;
            mask_two     <= 6'h00;
            fan_prescale <= 4'(`HWM_FDIV_RST >> 4);
        end else if (data_wr) begin
            unique case (index_pointer)
                `HWM_IDX_CFG: begin
                    cfg_suspend <= port_wdata[`HWM_CFG_SUSPEND];
                    cfg_irq_en  <= port_wdata[`HWM_CFG_IRQ_EN];
                    cfg_start   <= port_wdata[`HWM_CFG_START];
                end
                `HWM_IDX_MASK1: mask_one <= port_wdata;
                `HWM_IDX_MASK2: mask_two <= port_wdata[5:0];
                `HWM_IDX_FDIV: fan_prescale <= port_wdata[7:4];
                default: ;
            endcase
        end
    end

    assign fan_two_div = fan_prescale[3:2];
    assign fan_one_div = fan_prescale[1:0];

    // Reserved value RAM locations hold nothing and read zero.
    function automatic logic vram_reserved(input logic [4:0] ofs);
        vram_reserved = ofs == 5'h01 || ofs == 5'h0A || ofs == 5'h0D
                        || ofs == 5'h0E || ofs >= 5'h1D;
    endfunction

    // POST RAM and value RAM; a converter sample wins over a host write.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            for (int i = 0; i < 32; i++) begin
                post_ram[i]  <= 8'h00;
                value_ram[i] <= 8'h00;
            end
        end else begin
            if (data_wr && in_post) begin
                post_ram[vram_ofs] <= port_wdata;
            end
            if (data_wr && in_vram && !vram_reserved(vram_ofs)) begin
                value_ram[vram_ofs] <= port_wdata;
            end
            if (sample_go && !vram_reserved(sample_offset)) begin
                value_ram[sample_offset] <= sample_data;
            end
        end
    end

    // Choose which limits a fresh reading is compared against.
    always_comb begin
        chk_kind = hwm_pkg::HWM_CHK_NONE;
        chk_lim  = 5'h00;
        chk_bit  = 4'd0;
        unique case (sample_offset)
            `HWM_OFS_CORE: begin
                chk_kind = hwm_pkg::HWM_CHK_VOLT;
                chk_lim  = `HWM_LIM_CORE;
                chk_bit  = `HWM_ST_CORE;
            end
            `HWM_OFS_V3V3: begin
                chk_kind = hwm_pkg::HWM_CHK_VOLT;
                chk_lim  = `HWM_LIM_V3V3;
                chk_bit  = `HWM_ST_V3V3;
            end
            `HWM_OFS_V5: begin
                chk_kind = hwm_pkg::HWM_CHK_VOLT;
                chk_lim  = `HWM_LIM_V5;
                chk_bit  = `HWM_ST_V5;
            end
            `HWM_OFS_P12: begin
                chk_kind = hwm_pkg::HWM_CHK_VOLT;
                chk_lim  = `HWM_LIM_P12;
                chk_bit  = `HWM_ST_P12;
            end
            `HWM_OFS_N12: begin
                chk_kind = hwm_pkg::HWM_CHK_VOLT;
                chk_lim  = `HWM_LIM_N12;
                chk_bit  = `HWM_ST_N12;
            end
            `HWM_OFS_N5: begin
                chk_kind = hwm_pkg::HWM_CHK_VOLT;
                chk_lim  = `HWM_LIM_N5;
                chk_bit  = `HWM_ST_N5;
            end
            `HWM_OFS_TEMP1: begin
                chk_kind = hwm_pkg::HWM_CHK_TEMP;
                chk_lim  = `HWM_LIM_TEMP1;
                chk_bit  = `HWM_ST_TEMP1;
            end
            `HWM_OFS_FAN_ONE: begin
                chk_kind = hwm_pkg::HWM_CHK_FAN;
                chk_lim  = `HWM_LIM_FAN_ONE;
                chk_bit  = `HWM_ST_FAN_ONE;
            end
            `HWM_OFS_FAN_TWO: begin
                chk_kind = hwm_pkg::HWM_CHK_FAN;
                chk_lim  = `HWM_LIM_FAN_TWO;
                chk_bit  = `HWM_ST_FAN_TWO;
            end
            default: ;
        endcase
    end

    // Limit compare; the second limit byte always follows the first.
    always_comb begin
        lim_hi        = value_ram[chk_lim];
        lim_lo        = value_ram[5'(chk_lim + 5'h01)];
        viol          = 1'b0;
        next_temp_hot = temp_hot;
        unique case (chk_kind)
            hwm_pkg::HWM_CHK_VOLT: begin
                viol = sample_data > lim_hi
                       || sample_data < lim_lo;
            end
            hwm_pkg::HWM_CHK_FAN: begin
                viol = sample_data > lim_hi;
            end
            hwm_pkg::HWM_CHK_TEMP: begin
                // Two-times mode: trip above high, then below hysteresis.
                if (!temp_hot && $signed(sample_data) > $signed(lim_hi)) begin
                    viol          = 1'b1;
                    next_temp_hot = 1'b1;
                end
                if (temp_hot && $signed(sample_data) < $signed(lim_lo)) begin
                    viol          = 1'b1;
                    next_temp_hot = 1'b0;
                end
            end
            hwm_pkg::HWM_CHK_NONE: viol = 1'b0;
        endcase
    end

    // Temperature one trip state for the two-times scheme.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            temp_hot <= 1'b0;
        end else if (soft_rst) begin
            temp_hot <= 1'b0;
        end else if (sample_go) begin
            temp_hot <= next_temp_hot;
        end
    end

    // Case-open latch; a new event in the clearing cycle is kept.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            case_latch <= 1'b0;
        end else if (case_rise) begin
            case_latch <= 1'b1;
        end else if (soft_rst || (data_wr && index_pointer == `HWM_IDX_CLR
                     && port_wdata[`HWM_CLR_CASE])) begin
            case_latch <= 1'b0;
        end
    end

    // Status events are taken only while monitoring runs.
    always_comb begin
        stat_set = 16'h0000;
        if (sample_go && viol) begin
            stat_set[chk_bit] = 1'b1;
        end
        stat_set[`HWM_ST_TEMP2] = monitor_active && thermal_two_event;
        stat_set[`HWM_ST_CASE]  = monitor_active && case_latch;
        stat_clr = {{8{data_rd && index_pointer == `HWM_IDX_STAT2}},
                    {8{data_rd && index_pointer == `HWM_IDX_STAT1}}};
        stat_used = {`HWM_STAT2_USED, `HWM_STAT1_USED};
        unmasked  = status & ~{2'b00, mask_two, mask_one};
    end

    // Sticky status; reading a status register clears it, set wins.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            status <= 16'h0000;
        end else if (soft_rst) begin
            status <= 16'h0000;
        end else begin
            status <= ((status & ~stat_clr) | stat_set)
                      & stat_used;
        end
    end

    // Interrupt latch and its active-low output.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            irq_pend       <= 1'b0;
            mgmt_irq_out_n <= 1'b1;
        end else begin
            if (soft_rst) begin
                irq_pend <= 1'b0;
            end else if (|(unmasked & ~stat_clr) && cfg_irq_en
                         && !cfg_suspend) begin
                irq_pend <= 1'b1;
            end else if (|stat_clr) begin
                irq_pend <= 1'b0;
            end
            mgmt_irq_out_n <= !(irq_pend && !cfg_suspend);
        end
    end

    // Data port read selection; unmapped indexes read zero.
    always_comb begin
        rd_value = 8'h00;
        if (in_post) begin
            rd_value = post_ram[vram_ofs];
        end else if (in_vram) begin
            if (!vram_reserved(vram_ofs)) begin
                rd_value = value_ram[vram_ofs];
            end
        end else begin
            unique case (index_pointer)
                `HWM_IDX_CFG: rd_value = {4'h0, cfg_suspend, 1'b0,
                                          cfg_irq_en, cfg_start};
                `HWM_IDX_STAT1: rd_value = status[7:0];
                `HWM_IDX_STAT2: rd_value = status[15:8];
                `HWM_IDX_MASK1: rd_value = mask_one;
                `HWM_IDX_MASK2: rd_value = {2'b00, mask_two};
                `HWM_IDX_FDIV: rd_value = {fan_prescale, 4'h0};
                default: rd_value = 8'h00;
            endcase
        end
    end

    // Read data is registered on the read strobe and held until the next.
    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            port_rdata <= 8'h00;
        end else if (port_rd) begin
            if (port_sel) begin
                port_rdata <= rd_value;
            end else begin
                port_rdata <= {index_busy, index_pointer};
            end
        end
    end

endmodule

// ---- tb.sv ----
// Self-checking bench for the monitor register bank.
// Assumes the package, the host model and the checker are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               sample_valid = 1'b0;
    logic [4:0]         sample_offset = 5'h00;
    hwm_pkg::hwm_byte_t sample_data = 8'h00;
    logic               thermal_two_event = 1'b0;
    logic               case_open_pin = 1'b0;
    logic               port_sel, port_wr, port_rd, irq_n, mon;
    hwm_pkg::hwm_byte_t port_wdata, port_rdata, d, v;
    hwm_pkg::hwm_byte_t post [4];
    logic [1:0]         div1, div2;
    logic [23:0]        m;
    int                 err_count = 0, cmp_count = 0, seed = 63, cyc = 0;
    hwm_register_bank i_hwm_register_bank (.clk(clk), .rst_n(rst_n),
        .port_sel(port_sel), .port_wr(port_wr), .port_rd(port_rd),
        .port_wdata(port_wdata), .port_rdata(port_rdata),
        .sample_valid(sample_valid), .sample_offset(sample_offset),
        .sample_data(sample_data), .thermal_two_event(thermal_two_event),
        .case_open_pin(case_open_pin), .mgmt_irq_out_n(irq_n),
        .monitor_active(mon), .fan_one_div(div1), .fan_two_div(div2));
    hwm_host_model i_hwm_host_model (.clk(clk), .port_rdata(port_rdata),
        .port_sel(port_sel), .port_wr(port_wr), .port_rd(port_rd),
        .port_wdata(port_wdata));
    // Clock at 20 MHz; the run needs about four hundred cycles, so 20000 is ample.
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    // Status register, limit index in the stepping window and status mask.
    function automatic logic [23:0] exp_map(input logic [4:0] o);
        case (o)
            5'h00: return 24'h416B01;
            5'h02: return 24'h416F04;
            5'h03: return 24'h417108;
            5'h04: return 24'h427301;
            5'h05: return 24'h427502;
            5'h06: return 24'h427704;
            5'h07: return 24'h417910;
            5'h08: return 24'h417B40;
            default: return 24'h417C80;
        endcase
    endfunction
    task automatic chk(input hwm_pkg::hwm_byte_t g, input hwm_pkg::hwm_byte_t e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rwr(input logic [6:0] i, input hwm_pkg::hwm_byte_t x);
        i_hwm_host_model.wr(1'b0, {1'b0, i});
        i_hwm_host_model.wr(1'b1, x);
    endtask
    task automatic rrd(input logic [6:0] i, input hwm_pkg::hwm_byte_t e);
        i_hwm_host_model.wr(1'b0, {1'b0, i});
        i_hwm_host_model.rd(1'b1, d);
        chk(d, e);
    endtask
    // One converter sample, then time for the interrupt path to settle.
    task automatic smp(input logic [4:0] o, input hwm_pkg::hwm_byte_t x);
        @(negedge clk);
        sample_valid  = 1'b1;
        sample_offset = o;
        sample_data   = x;
        @(negedge clk);
        sample_valid  = 1'b0;
        sample_data   = ~x;
        repeat (3) @(negedge clk);
    endtask
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk({4'h0, div2, div1}, 8'h05);
        rrd(7'h40, 8'h01);
        rrd(7'h41, 8'h00);
        rrd(7'h44, 8'h00);
        rrd(7'h47, 8'h50);
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'h7E : 8'h1E;
            i_hwm_host_model.wr(1'b0, v);
            i_hwm_host_model.rd(1'b0, d);
            chk(d, v | 8'h80);
            i_hwm_host_model.rd(1'b1, d);
            i_hwm_host_model.wr(1'b1, d);
            i_hwm_host_model.rd(1'b0, d);
            chk(d, v + 8'h01);
        end
        i_hwm_host_model.wr(1'b0, 8'h00);
        for (int k = 0; k < 4; k++) begin
            post[k] = 8'($random(seed));
            i_hwm_host_model.wr(1'b1, post[k]);
        end
        i_hwm_host_model.wr(1'b0, 8'h00);
        for (int k = 0; k < 4; k++) begin
            i_hwm_host_model.rd(1'b1, d);
            chk(d, post[k]);
        end
        v = 8'($random(seed));
        rwr(7'h2B, v);
        i_hwm_host_model.rd(1'b0, d);
        chk(d, 8'h2B);
        rrd(7'h6B, v);
        i_hwm_host_model.rd(1'b0, d);
        chk(d, 8'h6C);
        for (int c = 0; c < 10; c++) begin
            if (c == 1) continue;
            m = exp_map(c[4:0]);
            rwr(m[14:8], 8'h40);
            i_hwm_host_model.wr(1'b1, 8'h30);
            v = 8'h41 + (8'($random(seed)) & 8'h3E);
            smp(c[4:0], v);
            rrd({2'b01, c[4:0]}, v);
            rrd(m[22:16], m[7:0]);
        end
        rwr(7'h40, 8'h03);
        smp(5'h00, 8'h45);
        chk({7'h00, irq_n}, 8'h00);
        rwr(7'h40, 8'h01);
        repeat (3) @(negedge clk);
        chk({7'h00, irq_n}, 8'h00);
        rwr(7'h40, 8'h03);
        rrd(7'h41, 8'h01);
        repeat (3) @(negedge clk);
        chk({7'h00, irq_n}, 8'h01);
        rwr(7'h43, 8'h01);
        rwr(7'h40, 8'h03);
        smp(5'h00, 8'h45);
        chk({7'h00, irq_n}, 8'h01);
        rrd(7'h41, 8'h01);
        rwr(7'h43, 8'h00);
        rwr(7'h40, 8'h0B);
        chk({7'h00, mon}, 8'h00);
        smp(5'h00, 8'h45);
        rrd(7'h41, 8'h00);
        rwr(7'h40, 8'h01);
        rwr(7'h6B, 8'hFF);
        smp(5'h00, 8'hFF);
        rrd(7'h41, 8'h00);
        smp(5'h00, 8'h05);
        rrd(7'h41, 8'h01);
        rwr(7'h40, 8'h00);
        chk({7'h00, mon}, 8'h00);
        smp(5'h00, 8'h05);
        rrd(7'h41, 8'h00);
        v = 8'($random(seed));
        rwr(7'h47, v);
        chk({4'h0, div2, div1}, {4'h0, v[7:4]});
        rwr(7'h40, 8'h80);
        rrd(7'h40, 8'h01);
        chk({4'h0, div2, div1}, 8'h05);
        thermal_two_event = 1'b1;
        @(negedge clk);
        thermal_two_event = 1'b0;
        repeat (2) @(negedge clk);
        rrd(7'h41, 8'h20);
        case_open_pin = 1'b1;
        repeat (6) @(negedge clk);
        case_open_pin = 1'b0;
        rrd(7'h42, 8'h10);
        rwr(7'h46, 8'h80);
        rrd(7'h42, 8'h10);
        rrd(7'h42, 8'h00);
        rrd(7'h46, 8'h00);
        rwr(7'h21, 8'hA5);
        rrd(7'h61, 8'h00);
        rwr(7'h44, 8'hFF);
        rrd(7'h44, 8'h3F);
        final_report();
    end
endmodule
